// file: core/dsp_defs.vh
/*
 * register addresses, field positions and timing counts for the digital
 * line port with its serial shifter.
 * assumes a 100 MHz system clock and a 16-bit register port.
 */
`ifndef DSP_DEFS_VH
`define DSP_DEFS_VH

// register addresses (16-bit register space)
`define DSP_ADDR_LINE_IN       7'h07
`define DSP_ADDR_LINE_OUT      7'h0a
`define DSP_ADDR_PORT_CTRL     7'h0b
`define DSP_ADDR_JOINT_STAT1   7'h1b
`define DSP_ADDR_SERIAL_BYTE   7'h1c
`define DSP_ADDR_JOINT_STAT2   7'h1d
`define DSP_ADDR_CLK_CONFIG    7'h38
`define DSP_ADDR_GEN_CTRL      7'h47

// field positions
`define DSP_BIT_GO             8
`define DSP_BIT_ENABLE         9
`define DSP_BIT_PERIOD_SEL     10
`define DSP_BIT_SW_STROBE      11
`define DSP_BIT_ACTIVE         12
`define DSP_BIT_HALVE          13
`define DSP_SER_OUT_LSB        8
`define DSP_GEN_LSB            8

// serial line positions within the bidirectional lines
`define DSP_SER_OUT_IDX        0
`define DSP_SER_IN_IDX         4

// serial timebase divider: slow timebase divided by 12
`define DSP_SLOW_DIV           12
// base timebase prescale: 100 MHz to a 20 MHz input timebase
`define DSP_BASE_PRESCALE      5
// bits in one serial transfer
`define DSP_SER_BITS           8
// sized end points of the counters
`define DSP_PRE_LAST           3'h4
`define DSP_DIV_MID            4'h5
`define DSP_DIV_LAST           4'hb
`define DSP_BIT_LAST           4'h7

// reset values
`define DSP_RST_BYTE           8'h00
`define DSP_RST_WORD           16'h0000

`endif

// file: core/dsp_port.v
/*
 * digital line port top: eight bidirectional lines, hardware serial shifter,
 * strobe pin, generic control outputs and status inputs behind a 16-bit
 * register port.
 * assumes synchronous pins and a single-cycle register read and write.
 */
`timescale 1ns/100ps
`include "dsp_defs.vh"

////////////////////////////////////////////////////////////////////////////
// Contract
// [R1] strobe pin is software output when serial off
// [R2] control bit 9 selects strobe pin owner
// [R3] start bit 8 self-clears, needs enable
// [R4] bit 10 picks divided or secondary timebase
// [R5] bit 13 of address 56 halves timebase
// [R6] software sets halving per oscillator fitted
// [R7] direction bits set each line in or out
// [R8] address 7 reads line levels
// [R9] output bits drive only output lines
// [R10] bits 8..15 at address 10 hold send byte
// [R11] address 28 returns received byte
// [R12] software avoids reading byte mid transfer
// [R13] active flag high during first seven bits
// [R14] software waits one period after flag falls
// [R15] strobe shows inverse of software bit 11
// [R16] address 71 bits 8..15 drive control pins
// [R17] address 29 bits 8..11 show status pins
// [R18] input sampled on strobe rising edge
// [R19] output changes on strobe falling edge
// [R20] most significant bit first both directions
// [R21] strobe pulses low once per bit
// [R22] start ignored while transfer runs
module dsp_port (
	input  wire        sys_clk,            // system clock, 100 MHz
	input  wire        rst_n,              // synchronous reset, active low
	input  wire        clk_en,             // freezes all state while low
	input  wire [6:0]  reg_addr,           // register address
	input  wire        reg_wr,             // write strobe
	input  wire        reg_rd,             // read strobe
	input  wire [15:0] reg_wdata,          // write data
	output reg  [15:0] reg_rdata,          // read data, registered
	input  wire [7:0]  bidir_lines_in,     // line levels at the pins
	output reg  [7:0]  bidir_lines_out,    // driven line levels
	output reg  [7:0]  bidir_lines_oe,     // high where the line drives
	output reg         strobe_serial_clock_pin, // strobe / serial clock
	output reg  [7:0]  generic_ctrl_pins,  // generic control outputs
	input  wire [3:0]  generic_status_pins, // generic status inputs
	input  wire        secondary_base_clock // second timebase input
);

	////////////////////////////////////////////////////////////////////////
	// register state
	reg  [7:0] line_direction_q;   // 1 output, 0 input
	reg  [7:0] line_levels_out_q;  // parallel output values
	reg  [7:0] shift_byte_out_q;   // serial send byte
	reg        hw_shift_enable_q;  // serial hardware owns strobe pin
	reg        shift_period_select_q; // serial period source
	reg        sw_strobe_level_q;  // software strobe level
	reg        shift_clock_halve_q; // halve input timebase
	reg  [7:0] gen_ctrl_q;         // generic control value
	reg        go_q;               // start pulse, self clearing

	wire       tick;               // half serial period tick
	wire       busy;               // transfer running
	wire       sh_strobe;          // shifter strobe level
	wire       sh_tx;              // shifter output bit
	wire [7:0] shift_byte_in;      // received byte
	wire       shift_active_flag;  // first seven bits running
	wire [7:0] line_levels_in;     // line levels as read back
	wire [7:0] drive_d;            // next line output values
	wire       ser_drive;          // serial bit owns line 0
	reg        strobe_d;           // next strobe pin level

	////////////////////////////////////////////////////////////////////////
	// timebase and shifter
	dsp_timebase u_tb (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.clk_en     (clk_en),
		.halve      (shift_clock_halve_q),
		.period_sel (shift_period_select_q),
		.sec_base   (secondary_base_clock),
		.tick       (tick)
	);

	dsp_shifter u_sh (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.tick    (tick),
		.start   (go_q),
		.tx_byte (shift_byte_out_q), // R10
		.rx_bit  (bidir_lines_in[`DSP_SER_IN_IDX]),
		.busy    (busy),
		.strobe  (sh_strobe),
		.tx_bit  (sh_tx),
		.rx_byte (shift_byte_in),
		.early   (shift_active_flag)
	);

	////////////////////////////////////////////////////////////////////////
	// register writes
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			line_direction_q      <= `DSP_RST_BYTE;
			line_levels_out_q     <= `DSP_RST_BYTE;
			shift_byte_out_q      <= `DSP_RST_BYTE;
			hw_shift_enable_q     <= 1'b0;
			shift_period_select_q <= 1'b0;
			sw_strobe_level_q     <= 1'b0;
			shift_clock_halve_q   <= 1'b0;
			gen_ctrl_q            <= `DSP_RST_BYTE;
			go_q                  <= 1'b0;
		end else if (clk_en) begin
			go_q <= 1'b0; // R3
			if (reg_wr) begin
				case (reg_addr)
					`DSP_ADDR_LINE_OUT: begin
						line_levels_out_q <= reg_wdata[7:0];
						shift_byte_out_q  <= reg_wdata[`DSP_SER_OUT_LSB +: 8]; // R10
					end
					`DSP_ADDR_PORT_CTRL: begin
						line_direction_q      <= reg_wdata[7:0]; // R7
						hw_shift_enable_q     <= reg_wdata[`DSP_BIT_ENABLE]; // R2
						shift_period_select_q <= reg_wdata[`DSP_BIT_PERIOD_SEL]; // R4
						sw_strobe_level_q     <= reg_wdata[`DSP_BIT_SW_STROBE];
						// start only when enabled in the same write and idle
						go_q <= reg_wdata[`DSP_BIT_GO] & reg_wdata[`DSP_BIT_ENABLE] & ~busy; // R3 R22
					end
					`DSP_ADDR_CLK_CONFIG: begin
						shift_clock_halve_q <= reg_wdata[`DSP_BIT_HALVE]; // R5
					end
					`DSP_ADDR_GEN_CTRL: begin
						gen_ctrl_q <= reg_wdata[`DSP_GEN_LSB +: 8]; // R16
					end
					default: begin
						go_q <= 1'b0; // other addresses store nothing
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-line drive and read-back
	// the last bit still stands on the cycle the strobe pin rises
	assign ser_drive = busy | (hw_shift_enable_q & ~strobe_serial_clock_pin); // R19

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_line
			if (g == `DSP_SER_OUT_IDX) begin : g_ser
				assign drive_d[g] = ser_drive ? sh_tx : line_levels_out_q[g];
			end else begin : g_par
				assign drive_d[g] = line_levels_out_q[g];
			end
			// output lines read back the driven value
			assign line_levels_in[g] = line_direction_q[g] ? bidir_lines_out[g] : bidir_lines_in[g]; // R8
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// strobe pin source select
	always @* begin
		if (hw_shift_enable_q)
			strobe_d = sh_strobe; // R2 R21
		else
			strobe_d = ~sw_strobe_level_q; // R1 R15
	end

	////////////////////////////////////////////////////////////////////////
	// registered pin outputs
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			bidir_lines_out         <= `DSP_RST_BYTE;
			bidir_lines_oe          <= `DSP_RST_BYTE;
			strobe_serial_clock_pin <= 1'b1;
			generic_ctrl_pins       <= `DSP_RST_BYTE;
		end else if (clk_en) begin
			bidir_lines_out         <= drive_d & line_direction_q; // R9
			bidir_lines_oe          <= line_direction_q; // R7
			strobe_serial_clock_pin <= strobe_d;
			generic_ctrl_pins       <= gen_ctrl_q; // R16
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register reads, one cycle after the strobe
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rdata <= `DSP_RST_WORD;
		end else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					`DSP_ADDR_LINE_IN:
						reg_rdata <= {8'h00, line_levels_in}; // R8
					`DSP_ADDR_JOINT_STAT1:
						reg_rdata <= {3'h0, shift_active_flag, 12'h000}; // R13
					`DSP_ADDR_SERIAL_BYTE:
						reg_rdata <= {8'h00, shift_byte_in}; // R11
					`DSP_ADDR_JOINT_STAT2:
						reg_rdata <= {4'h0, generic_status_pins, 8'h00}; // R17
					default:
						reg_rdata <= `DSP_RST_WORD;
				endcase
			end
		end
	end

endmodule

// file: core/dsp_shifter.v
/*
 * eight-bit serial shifter: drives the strobe low for the first half of
 * each bit, changes output on the falling edge, samples on the rising edge.
 * assumes ticks arrive at half serial periods.
 */
`timescale 1ns/100ps
`include "dsp_defs.vh"

module dsp_shifter (
	input  wire       sys_clk,   // system clock
	input  wire       rst_n,     // synchronous reset, active low
	input  wire       clk_en,    // freezes state while low
	input  wire       tick,      // half period tick
	input  wire       start,     // begin a transfer
	input  wire [7:0] tx_byte,   // byte to send
	input  wire       rx_bit,    // serial input level
	output reg        busy,      // transfer running
	output reg        strobe,    // serial clock level
	output reg        tx_bit,    // serial output level
	output reg  [7:0] rx_byte,   // collected byte
	output wire       early      // one of the first seven bits running
);

	reg [7:0] sh_q;   // outgoing shift register
	reg [3:0] cnt_q;  // bit counter

	assign early = busy & (cnt_q < `DSP_BIT_LAST); // R13

	////////////////////////////////////////////////////////////////////////
	// shift sequencer
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			busy    <= 1'b0;
			strobe  <= 1'b1;
			tx_bit  <= 1'b0;
			rx_byte <= `DSP_RST_BYTE;
			sh_q    <= `DSP_RST_BYTE;
			cnt_q   <= 4'h0;
		end else if (clk_en) begin
			if (!busy) begin
				if (start) begin
					busy  <= 1'b1; // R22
					sh_q  <= tx_byte;
					cnt_q <= 4'h0;
				end
			end else if (tick) begin
				if (strobe) begin
					strobe <= 1'b0; // R21
					tx_bit <= sh_q[7]; // R19 R20
					sh_q   <= {sh_q[6:0], 1'b0};
				end else begin
					strobe  <= 1'b1;
					rx_byte <= {rx_byte[6:0], rx_bit}; // R18 R20
					if (cnt_q == `DSP_BIT_LAST)
						busy <= 1'b0;
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
	end

endmodule

// file: core/dsp_timebase.v
/*
 * serial clock enable generator: prescales the system clock to an input
 * timebase, optionally halves it, divides by twelve, or picks the second
 * timebase input, and emits a one-cycle tick per half serial period.
 * assumes the secondary timebase is a synchronous level input.
 */
`timescale 1ns/100ps
`include "dsp_defs.vh"

module dsp_timebase (
	input  wire       sys_clk,     // system clock
	input  wire       rst_n,       // synchronous reset, active low
	input  wire       clk_en,      // freezes state while low
	input  wire       halve,       // halve the input timebase
	input  wire       period_sel,  // 0 divide by 12, 1 secondary timebase
	input  wire       sec_base,    // secondary base clock level
	output reg        tick         // one pulse per half serial period
);

	reg [2:0] pre_q;   // prescaler to input timebase
	reg       half_q;  // halving toggle
	reg [3:0] div_q;   // divide-by-12 counter
	reg       sec_q;   // previous secondary base level
	wire      base_tick;
	wire      slow_tick;
	wire      div_tick;

	assign base_tick = (pre_q == `DSP_PRE_LAST);
	assign slow_tick = base_tick & (~halve | half_q);
	assign div_tick  = slow_tick & ((div_q == `DSP_DIV_MID) | (div_q == `DSP_DIV_LAST));

	////////////////////////////////////////////////////////////////////////
	// counters: tick at both halves of the divided period
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			pre_q  <= 3'h0;
			half_q <= 1'b0;
			div_q  <= 4'h0;
			sec_q  <= 1'b0;
			tick   <= 1'b0;
		end else if (clk_en) begin
			pre_q <= base_tick ? 3'h0 : pre_q + 3'h1;
			if (base_tick)
				half_q <= ~half_q; // R5
			if (slow_tick)
				div_q <= (div_q == `DSP_DIV_LAST) ? 4'h0 : div_q + 4'h1;
			sec_q <= sec_base;
			if (period_sel)
				tick <= sec_base ^ sec_q; // R4
			else
				tick <= div_tick; // R4
		end
	end

endmodule

// file: tb/dsp_chk.sv
/* assertions on the pins of the line port
   assumes clk_en held high; bound to dsp_port below */
`timescale 1ns/100ps
module dsp_chk (
	input wire        sys_clk, // clock
	input wire        rst_n, // reset
	input wire        clk_en, // run
	input wire [6:0]  reg_addr, // address
	input wire        reg_wr, // write
	input wire        reg_rd, // read
	input wire [15:0] reg_wdata, // write data
	input wire [15:0] reg_rdata, // read data
	input wire [7:0]  bidir_lines_in, // pin levels
	input wire [7:0]  bidir_lines_out, // driven levels
	input wire [7:0]  bidir_lines_oe, // enables
	input wire        strobe_serial_clock_pin, // strobe
	input wire [7:0]  generic_ctrl_pins, // control
	input wire [3:0]  generic_status_pins, // status
	input wire        secondary_base_clock // timebase
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_n);
wire ctl_wr = reg_wr && reg_addr == 7'h0b; // port control write
////////////////////////////////////////////////////////////////////////////
property p_rst;
	$rose(rst_n) |-> strobe_serial_clock_pin && generic_ctrl_pins == 8'h00 && bidir_lines_oe == 8'h00;
endproperty
a_rst: assert property (p_rst) else $error("reset levels wrong");
property p_oe;
	ctl_wr |-> ##2 bidir_lines_oe == $past(reg_wdata[7:0], 2);
endproperty
a_oe: assert property (p_oe) else $error("direction not applied");
property p_zero;
	(bidir_lines_out & ~bidir_lines_oe) == 8'h00;
endproperty
a_zero: assert property (p_zero) else $error("input line driven");
property p_ctrl;
	reg_wr && reg_addr == 7'h47 |-> ##2 generic_ctrl_pins == $past(reg_wdata[15:8], 2);
endproperty
a_ctrl: assert property (p_ctrl) else $error("control pins wrong");
property p_rdin;
	reg_rd && reg_addr == 7'h07 |=> reg_rdata == {8'h00, $past(bidir_lines_in)};
endproperty
a_rdin: assert property (p_rdin) else $error("line read wrong");
property p_stat;
	reg_rd && reg_addr == 7'h1d |=> reg_rdata[11:8] == $past(generic_status_pins);
endproperty
a_stat: assert property (p_stat) else $error("status read wrong");
property p_wo;
	reg_rd && reg_addr == 7'h0b |=> reg_rdata == 16'h0000;
endproperty
a_wo: assert property (p_wo) else $error("write only read not zero");
property p_sw;
	ctl_wr && !reg_wdata[9] |-> ##2 strobe_serial_clock_pin == !$past(reg_wdata[11], 2);
endproperty
a_sw: assert property (p_sw) else $error("software strobe wrong");
property p_low;
	$fell(strobe_serial_clock_pin) |-> !strobe_serial_clock_pin [*8];
endproperty
a_low: assert property (p_low) else $error("strobe pulse too short");
endmodule
bind dsp_port dsp_chk chk_i (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
	.bidir_lines_in, .bidir_lines_out, .bidir_lines_oe, .strobe_serial_clock_pin, .generic_ctrl_pins,
	.generic_status_pins, .secondary_base_clock);

// file: tb/dsp_pins.sv
/* outside circuit on the lines: resolves pins, feeds line 4, watches line 0
   assumes the strobe pin clocks both directions */
`timescale 1ns/100ps
module dsp_pins (
	input  wire  [7:0] lines_out, // port levels
	input  wire  [7:0] lines_oe, // port enables
	input  wire        strobe, // strobe pin
	input  wire  [7:0] ext, // outside levels
	input  wire        load, // toggles to load
	input  wire  [7:0] send, // byte for line 4
	output wire  [7:0] lines_in, // pin levels
	output logic [7:0] seen // byte seen on line 0
);
logic [7:0] tx_q = 8'h00; // outgoing bits
// the driver with its enable high owns the pin
assign lines_in = (lines_out & lines_oe) | ({ext[7:5], tx_q[7], ext[3:0]} & ~lines_oe);
always @(load) tx_q = send;
// move on after the rising strobe so data stands over the sampling edge
always @(posedge strobe) tx_q <= {tx_q[6:0], ~tx_q[0]};
always @(posedge strobe) seen <= {seen[6:0], lines_out[0]};
endmodule

// file: tb/testbench.sv
/* bench: register access, software strobe and serial runs
   assumes dsp_port, dsp_pins and the bound checker */
`timescale 1ns/100ps
`define CHK(n,e,g) begin samples_checked++; if ((e)!==(g)) begin num_errors++; $display("mismatch %s exp %h got %h",n,e,g); end end
module testbench;
logic        sys_clk = 0, rst_n = 0, wr = 0, rd = 0, sec = 0, load = 0; // drives
logic [6:0]  addr = 7'h00; // address
logic [15:0] wd = 16'h0000, rdat; // bus data
logic [7:0]  lin, lout, loe, gpin, seen, ext = 8'h00, rxb = 8'h00; // pins
logic [3:0]  st = 4'h0; // status pins
logic        stb; // strobe pin
int          num_errors = 0, samples_checked = 0, nf = 0, lo = 0, lw = 0; // counts
dsp_port uut (.sys_clk, .rst_n, .clk_en(1'b1), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd),
	.reg_rdata(rdat), .bidir_lines_in(lin), .bidir_lines_out(lout), .bidir_lines_oe(loe),
	.strobe_serial_clock_pin(stb), .generic_ctrl_pins(gpin), .generic_status_pins(st), .secondary_base_clock(sec));
dsp_pins ext_m (.lines_out(lout), .lines_oe(loe), .strobe(stb), .ext, .load, .send(rxb), .lines_in(lin), .seen);
initial forever #5 sys_clk = ~sys_clk;
always begin
	repeat (13) @(posedge sys_clk);
	sec <= ~sec;
end
// strobe monitor: width of the last low pulse and count of falls
always @(posedge sys_clk) begin
	if (!stb) lo <= lo + 1;
	else if (lo != 0) begin
		lw <= lo;
		lo <= 0;
	end
	if ($fell(stb)) nf <= nf + 1;
end
task automatic wr16(input [6:0] a, input [15:0] d);
	@(posedge sys_clk);
	addr <= a;
	wd <= d;
	wr <= 1;
	@(posedge sys_clk);
	wr <= 0;
endtask
task automatic rd16(input [6:0] a, output [15:0] d);
	@(posedge sys_clk);
	addr <= a;
	rd <= 1;
	@(posedge sys_clk);
	rd <= 0;
	@(posedge sys_clk);
	#1 d = rdat;
endtask
task report_and_stop;
	if (num_errors == 0 && samples_checked > 0) $display("Test passed");
	else $display("Test failed");
	$finish;
endtask
initial begin
	#400000;
	num_errors++;
	report_and_stop();
end
initial begin
	logic [15:0] r;
	logic [7:0]  d, o, c, t, x;
	int          e, k, h, nb;
	void'($urandom(40));
	repeat (20) @(posedge sys_clk);
	rst_n <= 1;
	for (int i = 0; i < 6; i++) begin
		d = $urandom;
		o = $urandom;
		c = $urandom;
		e = $urandom;
		wr16(7'h0b, {8'h00, d});
		wr16(7'h0a, {8'h00, o});
		wr16(7'h47, {c, 8'h00});
		@(posedge sys_clk);
		ext <= e[7:0];
		st <= e[11:8];
		rd16(7'h07, r);
		`CHK("lines", {8'h00, (o & d) | (e[7:0] & 8'hef & ~d)}, r)
		`CHK("direction", d, loe)
		`CHK("outputs", o & d, lout)
		`CHK("control", c, gpin)
		rd16(7'h1d, r);
		`CHK("status", e[11:8], r[11:8])
	end
	rd16(7'h0b, r);
	`CHK("write only", 16'h0000, r)
	wr16(7'h0b, 16'h0901);
	repeat (80) @(posedge sys_clk);
	#1 `CHK("sw strobe", 1'b0, stb)
	`CHK("no start", 1, nf)
	wr16(7'h0b, 16'h0001);
	repeat (2) @(posedge sys_clk);
	#1 `CHK("sw strobe", 1'b1, stb)
	for (int m = 0; m < 3; m++) begin
		h = (m == 2) ? 13 : 30 * (m + 1);
		t = $urandom;
		x = $urandom;
		wr16(7'h38, {2'b00, m == 1, 13'h0000});
		wr16(7'h0a, {t, 8'h00});
		@(posedge sys_clk);
		rxb <= x;
		load <= ~load;
		nb = nf;
		wr16(7'h0b, {5'h00, m == 2, 10'h301});
		k = 0;
		do begin
			rd16(7'h1b, r);
			k++;
		end while (r[12] !== 1'b1 && k < 40);
		`CHK("active", 1'b1, r[12])
		wr16(7'h0b, {5'h00, m == 2, 10'h301});
		do begin
			rd16(7'h1b, r);
			k++;
		end while (r[12] !== 1'b0 && k < 900);
		`CHK("active end", 1'b0, r[12])
		repeat (4 * h) @(posedge sys_clk);
		#1 `CHK("falls", 8, nf - nb)
		`CHK("half period", h, lw)
		`CHK("sent", t, seen)
		`CHK("idle", 1'b1, stb)
		rd16(7'h1c, r);
		`CHK("received", x, r[7:0])
	end
	report_and_stop();
end
endmodule
